// >>> core/iuo_pkg.sv
// package: constants and carrier types of the step unit
package iuo_pkg;

    // ==========================================================
    // instruction word layout
    localparam int IUO_OPCODE_MSB = 31;
    localparam int IUO_OPCODE_LSB = 24;
    localparam int IUO_FLAGS_MSB = 23;
    localparam int IUO_FLAGS_LSB = 18;
    localparam int IUO_THIRD_MSB = 17;
    localparam int IUO_THIRD_LSB = 12;
    localparam int IUO_SRC_MSB = 11;
    localparam int IUO_SRC_LSB = 6;
    localparam int IUO_DST_MSB = 5;
    localparam int IUO_DST_LSB = 0;

    // flag positions inside the 6-bit flags field (field bit 0 is word bit 18)
    localparam int IUO_FLAG_SIZE_MSB = 5;
    localparam int IUO_FLAG_SIZE_LSB = 4;
    localparam int IUO_FLAG_SIMD = 3;
    localparam int IUO_FLAG_COMPL = 1;
    localparam int IUO_FLAG_REVERSE = 0;

    // size codes
    localparam logic [1:0] IUO_SIZE_8 = 2'h0;
    localparam logic [1:0] IUO_SIZE_16 = 2'h1;
    localparam logic [1:0] IUO_SIZE_32 = 2'h2;
    localparam logic [1:0] IUO_SIZE_64 = 2'h3;

    localparam int IUO_DATA_W = 64;
    localparam int IUO_MAX_CHUNKS = 8;

    // opcodes (plain values)
    localparam logic [7:0] IUO_STEP_UP_OPCODE = 8'h01;
    localparam logic [7:0] IUO_STEP_DOWN_OPCODE = 8'h02;
    localparam logic [7:0] IUO_SIGN_FLIP_OPCODE = 8'h03;
    localparam logic [7:0] IUO_BIT_FIND_OPCODE = 8'h04;
    localparam logic [7:0] IUO_LESS_THAN_OPCODE = 8'h05;
    localparam logic [7:0] IUO_LESS_OR_EQUAL_OPCODE = 8'h06;

    // ==========================================================
    // register map (byte addresses)
    localparam logic [7:0] IUO_REG_INSTR = 8'h00;
    localparam logic [7:0] IUO_REG_SRC_LO = 8'h04;
    localparam logic [7:0] IUO_REG_SRC_HI = 8'h08;
    localparam logic [7:0] IUO_REG_THIRD_LO = 8'h0c;
    localparam logic [7:0] IUO_REG_THIRD_HI = 8'h10;
    localparam logic [7:0] IUO_REG_RES_LO = 8'h14;
    localparam logic [7:0] IUO_REG_RES_HI = 8'h18;
    localparam logic [7:0] IUO_REG_STATUS = 8'h1c;

    // status fields
    localparam int IUO_STAT_DONE = 0;
    localparam int IUO_STAT_BAD_OP = 1;
    localparam int IUO_STAT_PEND = 2;
    localparam int IUO_STAT_DEST_LSB = 8;

    localparam logic [1:0] IUO_RESP_OKAY = 2'h0;
    localparam logic [1:0] IUO_RESP_SLVERR = 2'h2;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic [7:0] opcode;
        logic [5:0] flags;
        logic [5:0] third_idx;
        logic [5:0] src_idx;
        logic [5:0] dst_idx;
    } iuo_instr_type;

    typedef struct packed {
        iuo_instr_type instr;
        logic [63:0] src_data;
        logic [63:0] third_data;
    } iuo_issue_type;

    typedef struct packed {
        logic [5:0] dest;
        logic [63:0] data;
        logic bad_op;
    } iuo_result_type;

endpackage

// >>> core/iuo_step_unit.sv
// step unit: increment, decrement, negate, bit find and compare with an axi4-lite register path
// ==========================================================
// Notes on behaviour
// - step up writes source plus one, wrapping to zero at chunk maximum.
// - step down writes source minus one, wrapping to all ones from zero.
// - sign flip writes complement of source plus one per chunk.
// - negating the most negative chunk value returns it unchanged, no trap.
// - instruction: opcode 31:24, flags 23:18, third 17:12, source 11:6, destination 5:0.
// - flag bits 23:22 select operand size: byte, double, quad or whole.
// - flag bit 21 set applies the operation to every packed chunk.
// - bit find reports lowest set bit position, least significant bit is one.
// - bit find without flag bit 19 of a source without set bits writes zero.
// - flag bit 18 reverses the source so scanning starts at the top.
// - reversed scan reports highest set bit, still numbered from the bottom.
// - complemented scan of an all-ones source writes zero.
// - less-than test writes all ones when source below third, else zeros.
// - less-or-equal test writes all ones when source not above third.
// - comparisons are unsigned and use a comparator, not a subtraction.
// - without simd the size limits the operation to the lowest chunk.
//
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps

module iuo_step_unit
    import iuo_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic issue_valid,
    input wire iuo_issue_type issue,
    output logic result_valid,
    output iuo_result_type result
);

    // ==========================================================
    // state
    typedef struct packed {
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic b_valid;
        logic [1:0] b_resp;
        logic r_valid;
        logic [31:0] r_data;
        logic [1:0] r_resp;
        iuo_instr_type sw_instr;
        logic [63:0] sw_src;
        logic [63:0] sw_third;
        logic sw_pend;
        logic [63:0] sw_res;
        logic sw_done;
        logic sw_bad;
        logic out_valid;
        iuo_result_type out;
    } iuo_state_type;

    iuo_state_type state_ff;
    iuo_state_type nxt_state;

    // ==========================================================
    // one chunk operation, operands already masked to the chunk
    function automatic logic [64:0] iuo_chunk(
        input iuo_instr_type ins,
        input logic [63:0] x,
        input logic [63:0] y,
        input logic [63:0] mask,
        input int w
    );
        logic [63:0] r;
        logic [63:0] xv;
        logic bad;
        int pos;
        r = '0;
        xv = '0;
        bad = 1'b0;
        pos = 0;
        case (ins.opcode)
            IUO_STEP_UP_OPCODE:
            begin
                r = (x + 64'h1) & mask;
            end
            IUO_STEP_DOWN_OPCODE:
            begin
                r = (x - 64'h1) & mask;
            end
            IUO_SIGN_FLIP_OPCODE:
            begin
                r = (~x + 64'h1) & mask;
            end
            IUO_BIT_FIND_OPCODE:
            begin
                xv = ins.flags[IUO_FLAG_COMPL] ? (~x & mask) : x;
                for (int i = 0; i < IUO_DATA_W; i++)
                begin
                    // reversed scan keeps the last hit, plain scan the first
                    if (i < w && xv[i] && (ins.flags[IUO_FLAG_REVERSE] || pos == 0))
                    begin
                        pos = i + 1;
                    end
                end
                r = 64'(pos);
            end
            IUO_LESS_THAN_OPCODE:
            begin
                r = (x < y) ? mask : 64'h0;
            end
            IUO_LESS_OR_EQUAL_OPCODE:
            begin
                r = (x <= y) ? mask : 64'h0;
            end
            default:
            begin
                bad = 1'b1;
            end
        endcase
        return {bad, r};
    endfunction

    // ==========================================================
    // whole operation across chunks
    function automatic logic [64:0] iuo_exec(
        input iuo_instr_type ins,
        input logic [63:0] a,
        input logic [63:0] b
    );
        logic [63:0] mask;
        logic [63:0] res;
        logic [64:0] one;
        logic bad;
        int w;
        mask = '0;
        res = '0;
        one = '0;
        bad = 1'b0;
        w = IUO_DATA_W;
        case (ins.flags[IUO_FLAG_SIZE_MSB:IUO_FLAG_SIZE_LSB])
            IUO_SIZE_8: w = 8;
            IUO_SIZE_16: w = 16;
            IUO_SIZE_32: w = 32;
            default: w = IUO_DATA_W;
        endcase
        mask = (w == IUO_DATA_W) ? '1 : ((64'h1 << w) - 64'h1);
        for (int c = 0; c < IUO_MAX_CHUNKS; c++)
        begin
            // each chunk computed alone, so nothing carries across
            if ((c * w < IUO_DATA_W) && (ins.flags[IUO_FLAG_SIMD] || c == 0))
            begin
                one = iuo_chunk(ins, (a >> (c * w)) & mask, (b >> (c * w)) & mask, mask, w);
                res = res | ((one[63:0] & mask) << (c * w));
                bad = one[64];
            end
        end
        return {bad, res};
    endfunction

    // merge a written word under byte strobes
    function automatic logic [31:0] iuo_merge(
        input logic [31:0] old,
        input logic [31:0] nw,
        input logic [3:0] strb
    );
        logic [31:0] m;
        m = old;
        for (int k = 0; k < 4; k++)
        begin
            if (strb[k])
            begin
                m[k * 8 +: 8] = nw[k * 8 +: 8];
            end
        end
        return m;
    endfunction

    // ==========================================================
    // next state
    logic aw_ok;
    logic w_ok;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    iuo_instr_type ex_instr;
    logic [63:0] ex_src;
    logic [63:0] ex_third;
    logic [64:0] ex_out;

    always_comb
    begin
        nxt_state = state_ff;
        aw_ok = state_ff.aw_got | (awvalid & awready);
        w_ok = state_ff.w_got | (wvalid & wready);
        wr_addr = state_ff.aw_got ? state_ff.aw_addr : awaddr;
        wr_data = state_ff.w_got ? state_ff.w_data : wdata;
        wr_strb = state_ff.w_got ? state_ff.w_strb : wstrb;

        // write address and data taken in either order
        if (awvalid && awready)
        begin
            nxt_state.aw_got = 1'b1;
            nxt_state.aw_addr = awaddr;
        end
        if (wvalid && wready)
        begin
            nxt_state.w_got = 1'b1;
            nxt_state.w_data = wdata;
            nxt_state.w_strb = wstrb;
        end
        if (bvalid && bready)
        begin
            nxt_state.b_valid = 1'b0;
        end
        if (aw_ok && w_ok)
        begin
            nxt_state.aw_got = 1'b0;
            nxt_state.w_got = 1'b0;
            nxt_state.b_valid = 1'b1;
            nxt_state.b_resp = IUO_RESP_OKAY;
            if (wr_addr == IUO_REG_INSTR)
            begin
                nxt_state.sw_instr = iuo_instr_type'(iuo_merge(32'(state_ff.sw_instr), wr_data, wr_strb));
                nxt_state.sw_pend = 1'b1;
                nxt_state.sw_done = 1'b0;
            end
            else if (wr_addr == IUO_REG_SRC_LO)
            begin
                nxt_state.sw_src[31:0] = iuo_merge(state_ff.sw_src[31:0], wr_data, wr_strb);
            end
            else if (wr_addr == IUO_REG_SRC_HI)
            begin
                nxt_state.sw_src[63:32] = iuo_merge(state_ff.sw_src[63:32], wr_data, wr_strb);
            end
            else if (wr_addr == IUO_REG_THIRD_LO)
            begin
                nxt_state.sw_third[31:0] = iuo_merge(state_ff.sw_third[31:0], wr_data, wr_strb);
            end
            else if (wr_addr == IUO_REG_THIRD_HI)
            begin
                nxt_state.sw_third[63:32] = iuo_merge(state_ff.sw_third[63:32], wr_data, wr_strb);
            end
            else if (wr_addr != IUO_REG_RES_LO && wr_addr != IUO_REG_RES_HI && wr_addr != IUO_REG_STATUS)
            begin
                nxt_state.b_resp = IUO_RESP_SLVERR;
            end
        end

        // read channel
        if (rvalid && rready)
        begin
            nxt_state.r_valid = 1'b0;
        end
        if (arvalid && arready)
        begin
            nxt_state.r_valid = 1'b1;
            nxt_state.r_resp = IUO_RESP_OKAY;
            nxt_state.r_data = '0;
            if (araddr == IUO_REG_INSTR)
            begin
                nxt_state.r_data = 32'(state_ff.sw_instr);
            end
            else if (araddr == IUO_REG_SRC_LO)
            begin
                nxt_state.r_data = state_ff.sw_src[31:0];
            end
            else if (araddr == IUO_REG_SRC_HI)
            begin
                nxt_state.r_data = state_ff.sw_src[63:32];
            end
            else if (araddr == IUO_REG_THIRD_LO)
            begin
                nxt_state.r_data = state_ff.sw_third[31:0];
            end
            else if (araddr == IUO_REG_THIRD_HI)
            begin
                nxt_state.r_data = state_ff.sw_third[63:32];
            end
            else if (araddr == IUO_REG_RES_LO)
            begin
                nxt_state.r_data = state_ff.sw_res[31:0];
            end
            else if (araddr == IUO_REG_RES_HI)
            begin
                nxt_state.r_data = state_ff.sw_res[63:32];
            end
            else if (araddr == IUO_REG_STATUS)
            begin
                nxt_state.r_data[IUO_STAT_DONE] = state_ff.sw_done;
                nxt_state.r_data[IUO_STAT_BAD_OP] = state_ff.sw_bad;
                nxt_state.r_data[IUO_STAT_PEND] = state_ff.sw_pend;
                nxt_state.r_data[IUO_STAT_DEST_LSB +: 6] = state_ff.sw_instr.dst_idx;
            end
            else
            begin
                nxt_state.r_resp = IUO_RESP_SLVERR;
            end
        end

        // execute: the issue port wins, a software launch waits for a free cycle
        ex_instr = issue_valid ? issue.instr : state_ff.sw_instr;
        ex_src = issue_valid ? issue.src_data : state_ff.sw_src;
        ex_third = issue_valid ? issue.third_data : state_ff.sw_third;
        ex_out = iuo_exec(ex_instr, ex_src, ex_third);
        nxt_state.out_valid = issue_valid;
        if (issue_valid)
        begin
            nxt_state.out.dest = ex_instr.dst_idx;
            nxt_state.out.data = ex_out[63:0];
            nxt_state.out.bad_op = ex_out[64];
        end
        else if (state_ff.sw_pend)
        begin
            nxt_state.sw_res = ex_out[63:0];
            nxt_state.sw_bad = ex_out[64];
            // a launch written in this same cycle stays pending
            nxt_state.sw_pend = aw_ok & w_ok & (wr_addr == IUO_REG_INSTR);
            nxt_state.sw_done = ~(aw_ok & w_ok & (wr_addr == IUO_REG_INSTR));
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // ==========================================================
    // outputs
    assign awready = ~state_ff.aw_got & ~state_ff.b_valid;
    assign wready = ~state_ff.w_got & ~state_ff.b_valid;
    assign bvalid = state_ff.b_valid;
    assign bresp = state_ff.b_resp;
    assign arready = ~state_ff.r_valid;
    assign rvalid = state_ff.r_valid;
    assign rdata = state_ff.r_data;
    assign rresp = state_ff.r_resp;
    assign result_valid = state_ff.out_valid;
    assign result = state_ff.out;

endmodule // iuo_step_unit

// >>> bench/iuo_step_checker.sv
// checker: port-level assertions of the step unit issue path
`timescale 1ns/1ps

module iuo_step_checker
    import iuo_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic issue_valid,
    input wire iuo_issue_type issue,
    input wire logic result_valid,
    input wire iuo_result_type result
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ==========================================================
    // named steps
    sequence s_op64(logic [7:0] op);
        issue_valid && issue.instr.opcode == op && issue.instr.flags[5:3] == 3'h6;
    endsequence

    sequence s_find_none;
        issue_valid && issue.instr.opcode == IUO_BIT_FIND_OPCODE && !issue.instr.flags[1] && issue.src_data == 64'h0;
    endsequence

    // ==========================================================
    // assertions
    a_result_next: assert property (issue_valid |=> result_valid)
        else $error("result missing one cycle after issue");
    a_result_cause: assert property (result_valid |-> $past(issue_valid))
        else $error("result without issue");
    a_dest_follow: assert property (issue_valid |=> result.dest == $past(issue.instr.dst_idx))
        else $error("destination index not carried");
    a_step_up_wide: assert property (s_op64(IUO_STEP_UP_OPCODE) |=> result.data == $past(issue.src_data) + 64'h1)
        else $error("wide step up wrong");
    a_step_down_wide: assert property (s_op64(IUO_STEP_DOWN_OPCODE) |=> result.data == $past(issue.src_data) - 64'h1)
        else $error("wide step down wrong");
    a_flip_wide: assert property (s_op64(IUO_SIGN_FLIP_OPCODE) |=> result.data == ~$past(issue.src_data) + 64'h1)
        else $error("wide sign flip wrong");
    a_less_wide: assert property (s_op64(IUO_LESS_THAN_OPCODE) |=>
        result.data == (($past(issue.src_data) < $past(issue.third_data)) ? {64{1'b1}} : 64'h0))
        else $error("wide less than wrong");
    a_less_eq_wide: assert property (s_op64(IUO_LESS_OR_EQUAL_OPCODE) |=>
        result.data == (($past(issue.src_data) <= $past(issue.third_data)) ? {64{1'b1}} : 64'h0))
        else $error("wide less or equal wrong");
    a_find_none: assert property (s_find_none |=> result.data == 64'h0)
        else $error("empty scan not zero");
endmodule // iuo_step_checker

bind iuo_step_unit iuo_step_checker chk_u (.aclk(aclk), .aresetn(aresetn), .issue_valid(issue_valid),
    .issue(issue), .result_valid(result_valid), .result(result));

// >>> bench/iuo_core_model.sv
// partner: issue stage of the core feeding the step unit
`timescale 1ns/1ps

module iuo_core_model
    import iuo_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic req_valid,
    input wire iuo_issue_type req,
    output logic issue_valid,
    output iuo_issue_type issue
);
    iuo_issue_type nxt_issue;

    // ==========================================================
    // word forming
    always_comb
    begin
        nxt_issue = req;
        nxt_issue.instr.flags[2] = 1'b0;
        if (req.instr.opcode != IUO_LESS_THAN_OPCODE && req.instr.opcode != IUO_LESS_OR_EQUAL_OPCODE)
        begin
            nxt_issue.instr.third_idx = 6'h0;
        end
    end

    // ==========================================================
    // issue register, idle payload scrambled
    always_ff @(posedge aclk)
    begin
        issue_valid <= aresetn && req_valid;
        if (!aresetn)
            issue <= '0;
        else
            issue <= req_valid ? nxt_issue : ~issue;
    end
endmodule // iuo_core_model

// >>> bench/tb.sv
// testbench: step unit issue path and register access
`timescale 1ns/1ps

module tb
    import iuo_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic bready = 1'b1;
    logic rready = 1'b1;
    logic [7:0] awaddr = 8'h0;
    logic [7:0] araddr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, result_valid, issue_valid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, rd, keep;
    logic req_valid = 1'b0;
    iuo_issue_type req = '0;
    iuo_issue_type issue;
    iuo_result_type result, e, sw_e;
    iuo_result_type exp_q[$];
    logic [63:0] a_v, b_v;
    logic [31:0] instr_w;
    logic [31:0] seed = 32'hfb2d;
    logic [63:0] vals [4] = '{64'h0, 64'hffffffffffffffff, 64'h8080808080808080, 64'hff05891213450100};
    int bad_count = 0;
    int n_checks = 0;
    int t;

    always #25 aclk = ~aclk;

    iuo_core_model core_u (.aclk(aclk), .aresetn(aresetn), .req_valid(req_valid), .req(req),
        .issue_valid(issue_valid), .issue(issue));

    iuo_step_unit dut_u (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .issue_valid(issue_valid), .issue(issue), .result_valid(result_valid),
        .result(result));

    // ==========================================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [63:0] rnd64();
        logic [63:0] v;
        seed = lfsr(seed);
        v[31:0] = seed;
        seed = lfsr(seed);
        v[63:32] = seed;
        return v;
    endfunction

    function automatic iuo_result_type ref_op(input iuo_instr_type i, input logic [63:0] a, input logic [63:0] b);
        iuo_result_type r;
        int w;
        int n;
        logic [63:0] m, x, y, z;
        w = 8 << i.flags[5:4];
        n = i.flags[3] ? 64 / w : 1;
        m = (w == 64) ? 64'hffffffffffffffff : (64'h1 << w) - 64'h1;
        r = '0;
        r.dest = i.dst_idx;
        for (int k = 0; k < n; k++)
        begin
            x = (a >> (k * w)) & m;
            y = (b >> (k * w)) & m;
            z = 64'h0;
            case (i.opcode)
                IUO_STEP_UP_OPCODE: z = x + 64'h1;
                IUO_STEP_DOWN_OPCODE: z = x - 64'h1;
                IUO_SIGN_FLIP_OPCODE: z = ~x + 64'h1;
                IUO_LESS_THAN_OPCODE: z = (x < y) ? m : 64'h0;
                IUO_LESS_OR_EQUAL_OPCODE: z = (x <= y) ? m : 64'h0;
                IUO_BIT_FIND_OPCODE:
                begin
                    if (i.flags[1])
                        x = ~x & m;
                    for (int j = 0; j < w; j++)
                        if (x[j] && (i.flags[0] || z == 64'h0))
                            z = 64'(j + 1);
                end
                default: r.bad_op = 1'b1;
            endcase
            r.data = r.data | ((z & m) << (k * w));
        end
        return r;
    endfunction

    task automatic conclude();
        if (bad_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [70:0] got, input logic [70:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tmo();
        bad_count++;
        conclude();
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (t = 0; t < 50; t++)
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid)
                break;
        end
        if (t == 50)
            tmo();
        chk(71'(bresp), 71'(er));
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
        araddr <= a;
        arvalid <= 1'b1;
        for (t = 0; t < 50; t++)
        begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid)
                break;
        end
        if (t == 50)
            tmo();
        d = rdata;
        chk(71'(rresp), 71'(er));
    endtask

    task automatic op(input logic [7:0] opc, input logic [5:0] fl, input logic [63:0] a, input logic [63:0] b);
        iuo_issue_type q;
        seed = lfsr(seed);
        q.instr.opcode = opc;
        q.instr.flags = fl;
        q.instr.third_idx = (opc > IUO_BIT_FIND_OPCODE) ? seed[17:12] : 6'h0;
        q.instr.src_idx = seed[11:6];
        q.instr.dst_idx = seed[5:0];
        q.src_data = a;
        q.third_data = b;
        req <= q;
        req_valid <= 1'b1;
        exp_q.push_back(ref_op(q.instr, a, b));
        @(posedge aclk);
    endtask

    // ==========================================================
    // result monitor
    always @(posedge aclk)
    begin
        if (result_valid === 1'b1)
        begin
            if (exp_q.size() == 0)
                tmo();
            else
            begin
                e = exp_q.pop_front();
                chk(result, e);
            end
        end
    end

    // ==========================================================
    // main sequence
    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_rd(IUO_REG_STATUS, IUO_RESP_OKAY, rd);
        chk(71'(rd), 71'h0);
        for (int o = 0; o < 7; o++)
            for (int f = 0; f < 32; f++)
                for (int v = 0; v < 6; v++)
                begin
                    a_v = (v < 4) ? vals[v] : rnd64();
                    b_v = v[0] ? a_v : rnd64();
                    op(8'(o), {f[4:3], f[2], 1'b0, (o == 4) ? f[1:0] : 2'h0}, a_v, b_v);
                end
        req_valid <= 1'b0;
        repeat (4) @(posedge aclk);
        chk(71'(exp_q.size()), 71'h0);
        instr_w = {IUO_STEP_UP_OPCODE, 6'h08, 6'h0, 6'h2, 6'h1};
        sw_e = ref_op(iuo_instr_type'(instr_w), vals[3], 64'h0);
        axi_wr(IUO_REG_SRC_LO, vals[3][31:0], IUO_RESP_OKAY);
        axi_wr(IUO_REG_SRC_HI, vals[3][63:32], IUO_RESP_OKAY);
        axi_wr(IUO_REG_INSTR, instr_w, IUO_RESP_OKAY);
        for (int p = 0; p < 20; p++)
        begin
            axi_rd(IUO_REG_STATUS, IUO_RESP_OKAY, rd);
            if (rd[0] === 1'b1)
                break;
        end
        chk(71'(rd), 71'h101);
        axi_rd(IUO_REG_RES_LO, IUO_RESP_OKAY, keep);
        chk(71'(keep), 71'(sw_e.data[31:0]));
        axi_rd(IUO_REG_RES_HI, IUO_RESP_OKAY, rd);
        chk(71'(rd), 71'(sw_e.data[63:32]));
        axi_wr(IUO_REG_RES_LO, 32'h5a5a5a5a, IUO_RESP_OKAY);
        axi_rd(IUO_REG_RES_LO, IUO_RESP_OKAY, rd);
        chk(71'(rd), 71'(keep));
        axi_wr(8'h40, 32'h1, IUO_RESP_SLVERR);
        axi_rd(8'h40, IUO_RESP_SLVERR, rd);
        chk(71'(rd), 71'h0);
        // byte strobes: only the two low bytes land
        wstrb <= 4'h3;
        axi_wr(IUO_REG_THIRD_LO, 32'ha5a5a5a5, IUO_RESP_OKAY);
        wstrb <= 4'hf;
        axi_rd(IUO_REG_THIRD_LO, IUO_RESP_OKAY, rd);
        chk(71'(rd), 71'h0000a5a5);
        // unknown opcode launched by software reports bad op
        axi_wr(IUO_REG_INSTR, {8'h07, 18'h0, 6'h3}, IUO_RESP_OKAY);
        for (int p = 0; p < 20; p++)
        begin
            axi_rd(IUO_REG_STATUS, IUO_RESP_OKAY, rd);
            if (rd[0] === 1'b1)
                break;
        end
        chk(71'(rd), 71'h303);
        conclude();
    end
endmodule // tb
